// *** mppt_pkg.sv ***
/*
 * constants and state encoding for the maximum power point tracker.
 * assumes a 25 mhz system clock and measurement inputs already on that clock.
 */
// Contract
// - one-shot search starts with the voltage setpoint slightly above open-circuit voltage.
// - current limit equals configured short-circuit current while tracking.
// - one-shot search waits one tracking interval between steps; minimum interval 5 ms.
// - one-shot search ends itself and switches dc input off once point found.
// - after one-shot search, found point voltage, current and power stay visible.
// - continuous tracking never ends by itself; only an outside stop ends it.
// - voltage falls until power drops by tolerance, then rises back; zigzag repeats.
// - tracking excursions stay at or below the maximum power point voltage.
// - tracking samples voltage and current once per tracking interval.
// - fast-track skips search and jumps to user point voltage and power.
// - after the jump, fast-track behaves exactly like continuous tracking; the code holds power limit at user power, not P_FULL.
// - fast-track keeps updating the latest point voltage, current and power.
// - user curve steps through up to 100 stored setpoints, storing one result each.
// - sweep runs start to end index; start within 1..end, end within start..100.
// - sweep repeats the configured number of times, at most 65535.
// - user curve dwells one tracking interval per point before advancing.
// - user curve end or manual stop switches dc input off, results stay readable.
// - after user curve, highest-power result set is reported as the point.
package mppt_pkg;
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          TICK_MS         = 1;
    localparam int          TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
    localparam logic [15:0] INTERVAL_MIN_MS = 16'h0005;
    localparam logic [15:0] INTERVAL_MAX_MS = 16'hea60;
    localparam logic [6:0]  CURVE_POINTS    = 7'h64;
    localparam logic [15:0] V_STEP          = 16'h0010;
    localparam logic [15:0] V_ABOVE         = 16'h0020;
    localparam logic [15:0] I_FULL          = 16'hffff;
    localparam logic [31:0] P_FULL          = 32'hffff_ffff;

    localparam logic [1:0]  MODE_ONE_SHOT   = 2'h0;
    localparam logic [1:0]  MODE_CONTINUOUS = 2'h1;
    localparam logic [1:0]  MODE_FAST       = 2'h2;
    localparam logic [1:0]  MODE_CURVE      = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_SEARCH = 5'b00010,
        ST_DOWN   = 5'b00100,
        ST_UP     = 5'b01000,
        ST_CURVE  = 5'b10000
    } mppt_state_t;
endpackage

// *** mppt_core.sv ***
/*
 * maximum power point tracker sequencer: one-shot search, continuous and
 * fast tracking, and a user-curve sweep with per-point result storage.
 * assumes voltage/current measurements come from logic on ref_clk_in and the
 * power stage follows the setpoint, current limit and dc enable outputs.
 */
`timescale 1ns/1ps
module mppt_core
    import mppt_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic        ref_clk_in,            // 25 mhz system clock
    input  wire logic        sys_rst_in,            // synchronous reset, high
    input  wire logic        start_in,              // one-cycle start pulse
    input  wire logic        stop_in,               // stop request, level or pulse
    input  wire logic [1:0]  mode_in,               // mode select at start
    input  wire logic [15:0] open_circuit_voltage_in, // panel open-circuit voltage
    input  wire logic [15:0] short_current_in,      // panel short-circuit current
    input  wire logic [15:0] interval_ms_in,        // tracking interval in ms
    input  wire logic [31:0] delta_p_in,            // power tolerance
    input  wire logic [15:0] point_voltage_set_in,  // fast-track voltage
    input  wire logic [31:0] point_power_set_in,    // fast-track power
    input  wire logic [6:0]  start_idx_in,          // sweep start index, 1-based
    input  wire logic [6:0]  end_idx_in,            // sweep end index, 1-based
    input  wire logic [15:0] reps_in,               // sweep repetitions
    input  wire logic        curve_wr_in,           // curve table write strobe
    input  wire logic [6:0]  curve_addr_in,         // curve table address 0..99
    input  wire logic [15:0] curve_data_in,         // curve table voltage
    input  wire logic [15:0] volt_meas_in,          // measured voltage
    input  wire logic [15:0] curr_meas_in,          // measured current
    input  wire logic [6:0]  result_addr_in,        // result read address 0..99
    output logic             dc_on_out,             // dc input enable
    output logic [15:0]      vset_out,              // voltage setpoint
    output logic [15:0]      ilimit_out,            // current limit
    output logic [31:0]      pset_out,              // power limit
    output logic [15:0]      point_voltage_out,     // point voltage result
    output logic [15:0]      point_current_out,     // point current result
    output logic [31:0]      point_power_out,       // point power result
    output logic             busy_out,              // function running
    output logic             done_out,              // one-cycle end pulse
    output logic [15:0]      result_volt_out,       // stored voltage at result_addr_in
    output logic [15:0]      result_curr_out,       // stored current at result_addr_in
    output logic [31:0]      result_power_out       // stored power at result_addr_in
);
    typedef struct packed {
        mppt_state_t state;
        logic        dc_on;
        logic        done;
        logic        one_shot;
        logic        first;
        logic [15:0] vset;
        logic [15:0] ilim;
        logic [31:0] pset;
        logic [31:0] delta;
        logic [15:0] interval;
        logic [31:0] prev_p;
        logic [15:0] prev_v;
        logic [15:0] prev_i;
        logic [31:0] best_p;
        logic [15:0] pt_v;
        logic [15:0] pt_i;
        logic [31:0] pt_p;
        logic [31:0] pre_cnt;
        logic [15:0] ms_cnt;
        logic [6:0]  idx;
        logic [6:0]  idx_start;
        logic [6:0]  idx_end;
        logic [15:0] rep_cnt;
        logic [15:0] passes;
    } mppt_regs_t;

    mppt_regs_t  st_reg;
    mppt_regs_t  st_next;

    logic [15:0] curve_mem [0:99];
    logic [15:0] res_v_mem [0:99];
    logic [15:0] res_i_mem [0:99];
    logic [31:0] res_p_mem [0:99];

    logic [31:0] p_meas;
    logic        tick;
    logic        step;
    logic        res_wr;
    logic [6:0]  res_waddr;
    logic [15:0] iv_eff;
    logic [6:0]  end_eff;
    logic [6:0]  start_eff;
    logic [16:0] v_up_sum;
    logic [16:0] v_above_sum;
    logic        found;
    logic        reverse;

    assign p_meas      = 32'(volt_meas_in) * 32'(curr_meas_in);
    assign tick        = (st_reg.pre_cnt == 32'(TICK_CYCLES - 1));
    assign step        = tick && (st_reg.ms_cnt == 16'h0001);
    assign iv_eff      = (interval_ms_in < INTERVAL_MIN_MS) ? INTERVAL_MIN_MS :
                         (interval_ms_in > INTERVAL_MAX_MS) ? INTERVAL_MAX_MS : interval_ms_in;
    assign end_eff     = (end_idx_in > CURVE_POINTS) ? CURVE_POINTS :
                         (end_idx_in == 7'h00) ? 7'h01 : end_idx_in;
    assign start_eff   = (start_idx_in == 7'h00) ? 7'h01 :
                         (start_idx_in > end_eff) ? end_eff : start_idx_in;
    assign v_up_sum    = 17'(st_reg.vset) + 17'(V_STEP);
    assign v_above_sum = 17'(open_circuit_voltage_in) + 17'(V_ABOVE);
    assign found       = !st_reg.first && (p_meas < st_reg.prev_p);
    assign reverse     = (33'(p_meas) + 33'(st_reg.delta)) <= 33'(st_reg.best_p);

    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        res_wr       = 1'b0;
        res_waddr    = st_reg.idx - 7'h01;
        // prescaler and interval counter only run while a function is active
        if (st_reg.state != ST_IDLE) begin
            st_next.pre_cnt = tick ? 32'h0000_0000 : st_reg.pre_cnt + 32'h0000_0001;
            if (tick) begin
                st_next.ms_cnt = step ? st_reg.interval : st_reg.ms_cnt - 16'h0001;
            end
        end
        case (st_reg.state)
            ST_IDLE: begin
                if (start_in && !stop_in) begin
                    st_next.dc_on    = 1'b1;
                    st_next.ilim     = short_current_in;
                    st_next.pset     = P_FULL;
                    st_next.delta    = delta_p_in;
                    st_next.interval = iv_eff;
                    st_next.ms_cnt   = iv_eff;
                    st_next.pre_cnt  = 32'h0000_0000;
                    st_next.first    = 1'b1;
                    st_next.best_p   = 32'h0000_0000;
                    st_next.one_shot = (mode_in == MODE_ONE_SHOT);
                    case (mode_in)
                        MODE_ONE_SHOT, MODE_CONTINUOUS: begin
                            st_next.vset  = v_above_sum[16] ? 16'hffff : v_above_sum[15:0];
                            st_next.state = ST_SEARCH;
                        end
                        MODE_FAST: begin
                            st_next.vset   = point_voltage_set_in;
                            st_next.pset   = point_power_set_in;
                            st_next.pt_v   = point_voltage_set_in;
                            st_next.best_p = point_power_set_in;
                            st_next.state  = ST_DOWN;
                        end
                        default: begin
                            st_next.ilim      = I_FULL;
                            st_next.idx       = start_eff;
                            st_next.idx_start = start_eff;
                            st_next.idx_end   = end_eff;
                            st_next.rep_cnt   = 16'h0001;
                            st_next.passes    = (reps_in == 16'h0000) ? 16'h0001 : reps_in;
                            st_next.vset      = curve_mem[start_eff - 7'h01];
                            st_next.state     = ST_CURVE;
                        end
                    endcase
                end
            end
            ST_SEARCH: begin
                if (step) begin
                    st_next.first = 1'b0;
                    if (found) begin
                        // previous step was the peak: keep its values
                        st_next.pt_v   = st_reg.prev_v;
                        st_next.pt_i   = st_reg.prev_i;
                        st_next.pt_p   = st_reg.prev_p;
                        st_next.best_p = st_reg.prev_p;
                        if (st_reg.one_shot) begin
                            st_next.dc_on = 1'b0;
                            st_next.done  = 1'b1;
                            st_next.state = ST_IDLE;
                        end else begin
                            st_next.vset  = st_reg.prev_v;
                            st_next.state = ST_DOWN;
                        end
                    end else begin
                        st_next.prev_p = p_meas;
                        st_next.prev_v = st_reg.vset;
                        st_next.prev_i = curr_meas_in;
                        st_next.vset   = (st_reg.vset > V_STEP) ? st_reg.vset - V_STEP : 16'h0000;
                    end
                end
            end
            ST_DOWN, ST_UP: begin
                if (step) begin
                    if (p_meas > st_reg.best_p) begin
                        // a new peak resets the tolerance reference
                        st_next.best_p = p_meas;
                        st_next.pt_v   = st_reg.vset;
                        st_next.pt_i   = curr_meas_in;
                        st_next.pt_p   = p_meas;
                    end
                    if (st_reg.state == ST_DOWN) begin
                        if (reverse) begin
                            st_next.state = ST_UP;
                        end else begin
                            st_next.vset = (st_reg.vset > V_STEP) ? st_reg.vset - V_STEP : 16'h0000;
                        end
                    end else if (v_up_sum >= 17'(st_reg.pt_v)) begin
                        st_next.vset  = st_reg.pt_v;
                        st_next.state = ST_DOWN;
                    end else begin
                        st_next.vset = v_up_sum[15:0];
                    end
                end
            end
            ST_CURVE: begin
                if (step) begin
                    res_wr = 1'b1;
                    if (p_meas >= st_reg.best_p) begin
                        st_next.best_p = p_meas;
                        st_next.pt_v   = volt_meas_in;
                        st_next.pt_i   = curr_meas_in;
                        st_next.pt_p   = p_meas;
                    end
                    if (st_reg.idx != st_reg.idx_end) begin
                        st_next.idx  = st_reg.idx + 7'h01;
                        st_next.vset = curve_mem[st_reg.idx];
                    end else if (st_reg.rep_cnt < st_reg.passes) begin
                        st_next.rep_cnt = st_reg.rep_cnt + 16'h0001;
                        st_next.idx     = st_reg.idx_start;
                        st_next.vset    = curve_mem[st_reg.idx_start - 7'h01];
                    end else begin
                        st_next.dc_on = 1'b0;
                        st_next.done  = 1'b1;
                        st_next.state = ST_IDLE;
                    end
                end
            end
            default: begin
                st_next.state = ST_IDLE;
                st_next.dc_on = 1'b0;
            end
        endcase
        // stop overrides everything; results are left untouched
        if (stop_in && st_reg.state != ST_IDLE) begin
            st_next.dc_on = 1'b0;
            st_next.done  = 1'b1;
            st_next.state = ST_IDLE;
            st_next.pt_v  = st_reg.pt_v;
            st_next.pt_i  = st_reg.pt_i;
            st_next.pt_p  = st_reg.pt_p;
            res_wr        = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            st_reg       <= '0;
            st_reg.state <= ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // memories carry no reset; unwritten entries are undefined until written
    always_ff @(posedge ref_clk_in) begin
        if (curve_wr_in && curve_addr_in < CURVE_POINTS) begin
            curve_mem[curve_addr_in] <= curve_data_in;
        end
        if (res_wr) begin
            res_v_mem[res_waddr] <= volt_meas_in;
            res_i_mem[res_waddr] <= curr_meas_in;
            res_p_mem[res_waddr] <= p_meas;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            result_volt_out  <= 16'h0000;
            result_curr_out  <= 16'h0000;
            result_power_out <= 32'h0000_0000;
        end else if (result_addr_in < CURVE_POINTS) begin
            result_volt_out  <= res_v_mem[result_addr_in];
            result_curr_out  <= res_i_mem[result_addr_in];
            result_power_out <= res_p_mem[result_addr_in];
        end else begin
            result_volt_out  <= 16'h0000;
            result_curr_out  <= 16'h0000;
            result_power_out <= 32'h0000_0000;
        end
    end

    assign dc_on_out         = st_reg.dc_on;
    assign vset_out          = st_reg.vset;
    assign ilimit_out        = st_reg.ilim;
    assign pset_out          = st_reg.pset;
    assign point_voltage_out = st_reg.pt_v;
    assign point_current_out = st_reg.pt_i;
    assign point_power_out   = st_reg.pt_p;
    assign busy_out          = (st_reg.state != ST_IDLE);
    assign done_out          = st_reg.done;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_start_above;
        (st_reg.state == ST_IDLE) && start_in && !stop_in && (mode_in == MODE_ONE_SHOT)
            && (open_circuit_voltage_in < 16'hff00)
            |=> (vset_out == $past(open_circuit_voltage_in) + V_ABOVE) && (st_reg.state == ST_SEARCH);
    endproperty
    a_start_above: assert property (p_start_above) else $error("search start setpoint wrong");

    property p_ilim;
        (st_reg.state == ST_IDLE) && start_in && !stop_in && (mode_in != MODE_CURVE)
            |=> (ilimit_out == $past(short_current_in))
                ##1 (ilimit_out == $past(short_current_in, 2))
                ##1 (ilimit_out == $past(short_current_in, 3));
    endproperty
    a_ilim: assert property (p_ilim) else $error("current limit not short-circuit current");

    property p_interval;
        step && busy_out && !stop_in |=> (st_reg.ms_cnt == st_reg.interval)
            && (st_reg.interval >= INTERVAL_MIN_MS);
    endproperty
    a_interval: assert property (p_interval) else $error("interval reload wrong");

    property p_one_shot_end;
        (st_reg.state == ST_SEARCH) && st_reg.one_shot && step && found && !stop_in
            |=> !dc_on_out && done_out && (point_power_out == $past(st_reg.prev_p));
    endproperty
    a_one_shot_end: assert property (p_one_shot_end) else $error("one-shot did not end");

    property p_keep_tracking;
        (st_reg.state == ST_DOWN || st_reg.state == ST_UP) && !stop_in |=> busy_out && dc_on_out;
    endproperty
    a_keep_tracking: assert property (p_keep_tracking) else $error("tracking ended by itself");

    property p_reverse;
        (st_reg.state == ST_DOWN) && step && reverse && !stop_in
            |=> (st_reg.state == ST_UP) && $stable(vset_out);
    endproperty
    a_reverse: assert property (p_reverse) else $error("no reversal at tolerance");

    property p_below;
        (st_reg.state == ST_DOWN || st_reg.state == ST_UP) |-> vset_out <= st_reg.pt_v;
    endproperty
    a_below: assert property (p_below) else $error("setpoint above point voltage");

    property p_fast_jump;
        (st_reg.state == ST_IDLE) && start_in && !stop_in && (mode_in == MODE_FAST)
            |=> (vset_out == $past(point_voltage_set_in)) && (pset_out == $past(point_power_set_in))
                && (st_reg.state == ST_DOWN);
    endproperty
    a_fast_jump: assert property (p_fast_jump) else $error("fast-track jump wrong");

    property p_curve_end;
        (st_reg.state == ST_CURVE) && step && (st_reg.idx == st_reg.idx_end)
            && (st_reg.rep_cnt >= st_reg.passes) |=> !dc_on_out && !busy_out;
    endproperty
    a_curve_end: assert property (p_curve_end) else $error("curve run did not stop");

    property p_stop;
        stop_in && busy_out |=> !dc_on_out && !busy_out && $stable(point_power_out);
    endproperty
    a_stop: assert property (p_stop) else $error("stop not honoured");

    c_one_shot_done: cover property ((st_reg.state == ST_SEARCH) && st_reg.one_shot ##1 done_out);
    c_reversal:      cover property ((st_reg.state == ST_DOWN) ##1 (st_reg.state == ST_UP));
    c_curve_repeat:  cover property ((st_reg.state == ST_CURVE) && step
                                     && (st_reg.idx == st_reg.idx_end) && (st_reg.rep_cnt < st_reg.passes));
    c_stop:          cover property (stop_in && busy_out);
endmodule

// *** mppt_panel_model.sv ***
/*
 * behavioural solar panel seen by the tracker's dc input.
 * assumes setpoint and enable come from mppt_core; answers combinationally.
 */
`timescale 1ns/1ps
module mppt_panel_model (
    input  wire logic        dc_on_in,  // load connected
    input  wire logic [15:0] vset_in,   // load voltage setpoint
    input  wire logic [15:0] voc_in,    // panel open-circuit voltage
    output logic      [15:0] volt_out,  // panel terminal voltage
    output logic      [15:0] curr_out   // panel current
);
    // flat current below the knee, linear fall to zero at open circuit
    always_comb begin
        volt_out = dc_on_in ? vset_in : voc_in;
        if (!dc_on_in || volt_out >= voc_in)
            curr_out = 16'h0000;
        else if (volt_out < voc_in - 16'h0040)
            curr_out = 16'h0040;
        else
            curr_out = voc_in - volt_out;
    end
endmodule

// *** max_power_point_tracker_test.sv ***
/*
 * self-checking bench for mppt_core with a panel model on the dc input.
 * assumes TICK_CYCLES of 4, so a 5 ms interval is 20 clock cycles.
 */
`timescale 1ns/1ps
module max_power_point_tracker_test;
    import mppt_pkg::*;
    logic        ref_clk_in = 1'b0, sys_rst_in = 1'b1, start_in = 1'b0, stop_in = 1'b0;
    logic        curve_wr_in = 1'b0, dc_on_out, busy_out, done_out;
    logic [1:0]  mode_in = 2'h0;
    logic [6:0]  start_idx_in = 7'h02, end_idx_in = 7'h04, curve_addr_in = 7'h00;
    logic [6:0]  result_addr_in = 7'h00;
    logic [15:0] open_circuit_voltage_in = 16'h0100, short_current_in = 16'h0040;
    logic [15:0] interval_ms_in = 16'h0003, point_voltage_set_in = 16'h0000;
    logic [15:0] reps_in = 16'h0002, curve_data_in = 16'h0000, lfsr = 16'h0040, vx;
    logic [15:0] volt_meas_in, curr_meas_in, vset_out, ilimit_out, point_voltage_out;
    logic [15:0] point_current_out, result_volt_out, result_curr_out, tbl [0:4];
    logic [31:0] delta_p_in = 32'h0000_0100, point_power_set_in = 32'h0000_0800, px;
    logic [31:0] pset_out, point_power_out, result_power_out;
    int          miscompares = 0, checked = 0, cyc = 0, n, ns;

    mppt_core #(.TICK_CYCLES(4)) dut_u (.ref_clk_in, .sys_rst_in, .start_in, .stop_in,
        .mode_in, .open_circuit_voltage_in, .short_current_in, .interval_ms_in, .delta_p_in,
        .point_voltage_set_in, .point_power_set_in, .start_idx_in, .end_idx_in, .reps_in,
        .curve_wr_in, .curve_addr_in, .curve_data_in, .volt_meas_in, .curr_meas_in,
        .result_addr_in, .dc_on_out, .vset_out, .ilimit_out, .pset_out, .point_voltage_out,
        .point_current_out, .point_power_out, .busy_out, .done_out, .result_volt_out,
        .result_curr_out, .result_power_out);
    mppt_panel_model panel_u (.dc_on_in(dc_on_out), .vset_in(vset_out),
        .voc_in(open_circuit_voltage_in), .volt_out(volt_meas_in), .curr_out(curr_meas_in));

    always #20 ref_clk_in = ~ref_clk_in;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] cur(input logic [15:0] v, input logic [15:0] voc);
        return (v >= voc) ? 16'h0000 : (v < voc - 16'h0040) ? 16'h0040 : voc - v;
    endfunction
    function automatic logic [31:0] pw(input logic [15:0] v, input logic [15:0] voc);
        return 32'(v) * 32'(cur(v, voc));
    endfunction
    // search walks down until power first drops; the point is the step before
    // ns counts the steps taken: the start point, every move and the losing step
    function automatic logic [31:0] peak(input logic [15:0] voc, output logic [15:0] pv,
                                         output int ns);
        logic [31:0] prev;
        pv = voc + V_ABOVE;
        prev = pw(pv, voc);
        ns = 2;
        while (pw(pv - V_STEP, voc) >= prev) begin
            pv = pv - V_STEP;
            prev = pw(pv, voc);
            ns++;
        end
        return prev;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic go(input logic [1:0] m);
        @(negedge ref_clk_in);
        mode_in = m;
        start_in = 1'b1;
        @(negedge ref_clk_in);
        start_in = 1'b0;
    endtask
    task automatic wait_done();
        n = 0;
        while (done_out !== 1'b1 && n < 4000) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk(n < 4000, 1'b1);
    endtask
    task automatic print_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        for (int k = 0; k < 3; k++) begin
            lfsr = lfsr_next(lfsr);
            open_circuit_voltage_in = 16'h0080 + {8'h00, lfsr[7:0]};
            go(MODE_ONE_SHOT);
            chk(vset_out, open_circuit_voltage_in + V_ABOVE);
            chk(ilimit_out, short_current_in);
            wait_done();
            @(negedge ref_clk_in);
            px = peak(open_circuit_voltage_in, vx, ns);
            chk(n, ns * 4 * INTERVAL_MIN_MS);
            chk(dc_on_out, 1'b0);
            chk(point_voltage_out, vx);
            chk(point_power_out, px);
            chk(point_current_out, px / vx);
        end
        for (int m = 1; m < 3; m++) begin
            lfsr = lfsr_next(lfsr);
            point_voltage_set_in = 16'h0080 + {9'h000, lfsr[6:0]};
            go(m[1:0]);
            if (m == 2) begin
                chk(vset_out, point_voltage_set_in);
                chk(point_voltage_out, point_voltage_set_in);
                chk(pset_out, point_power_set_in);
            end
            repeat (400) @(negedge ref_clk_in);
            if (m == 1)
                chk(point_power_out, px);
            repeat (200) begin
                @(negedge ref_clk_in);
                chk(busy_out, 1'b1);
                chk(vset_out <= point_voltage_out, 1'b1);
            end
            stop_in = 1'b1;
            @(negedge ref_clk_in);
            stop_in = 1'b0;
            chk({busy_out, dc_on_out, done_out}, 3'b001);
        end
        for (int k = 0; k < 5; k++) begin
            lfsr = lfsr_next(lfsr);
            tbl[k] = {7'h00, lfsr[8:0]};
            @(negedge ref_clk_in);
            curve_wr_in = 1'b1;
            curve_addr_in = k[6:0];
            curve_data_in = tbl[k];
        end
        @(negedge ref_clk_in);
        curve_wr_in = 1'b0;
        open_circuit_voltage_in = 16'h0100;
        go(MODE_CURVE);
        chk(vset_out, tbl[1]);
        chk(ilimit_out, I_FULL);
        wait_done();
        chk(n > 110 && n < 130, 1'b1);
        @(negedge ref_clk_in);
        chk(dc_on_out, 1'b0);
        px = 32'h0000_0000;
        for (int k = 1; k < 4; k++) begin
            result_addr_in = k[6:0];
            @(negedge ref_clk_in);
            chk(result_volt_out, tbl[k]);
            chk(result_curr_out, cur(tbl[k], 16'h0100));
            chk(result_power_out, pw(tbl[k], 16'h0100));
            if (pw(tbl[k], 16'h0100) >= px) begin
                px = pw(tbl[k], 16'h0100);
                vx = tbl[k];
            end
        end
        chk(point_power_out, px);
        chk(point_voltage_out, vx);
        print_verdict();
    end
endmodule
